// ===== ppe_pkg.sv
//------------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------------
// Functional notes
// - Primary master bit only when bridge masters primary.
// - Primary master bit needs primary response enable.
// - Primary trigger: sampled error or own mismatch.
// - Primary bit: upstream read/posted/delayed, primary error.
// - Secondary master bit only when bridge masters secondary.
// - Secondary bit and signal need secondary enable.
// - Secondary trigger: sampled error or own mismatch.
// - Secondary bit: downstream read/posted/delayed, secondary error.
// - Drive primary error only as write target/read initiator.
// - Driving primary error needs primary enable.
// - Secondary error on downstream delayed write forwards upward.
// - Primary error asserted for listed primary cases.
// - Drive secondary error only as write target/read initiator.
// - Primary error on upstream delayed write forwards downward.
// - Secondary error asserted for listed secondary cases.
package ppe_pkg;

   //---------------------------------------------------------------------------
   // Register map
   //---------------------------------------------------------------------------
   // Address width of the register port.
   localparam int ADDR_W = 4;
   // Read-only sticky status.
   localparam logic [3:0] OFF_STATUS = 4'h0;
   // Write-one-to-clear register.
   localparam logic [3:0] OFF_CLEAR = 4'h1;
   // Interrupt enable register.
   localparam logic [3:0] OFF_IRQEN = 4'h2;
   // Control register holding the two response enables.
   localparam logic [3:0] OFF_CTRL = 4'h3;

   //---------------------------------------------------------------------------
   // Field positions and reset values
   //---------------------------------------------------------------------------
   // Primary master data parity detected.
   localparam int BIT_PRI = 0;
   // Secondary master data parity detected.
   localparam int BIT_SEC = 1;
   // Control: primary parity error response enable.
   localparam int BIT_PRI_EN = 0;
   // Control: secondary parity error response enable.
   localparam int BIT_SEC_EN = 1;
   // Reset values.
   localparam logic [1:0] RST_CTRL  = 2'h0;
   localparam logic [1:0] RST_IRQEN = 2'h0;

   //---------------------------------------------------------------------------
   // Transaction attributes
   //---------------------------------------------------------------------------
   // Kind of transaction in flight.
   typedef enum logic [1:0] {KIND_READ, KIND_POSTED, KIND_DELAYED, KIND_NONE} ppe_kind_type;

endpackage : ppe_pkg

// ===== ppe_sticky.sv
`timescale 1ns/1ns
// Sticky event bit: set wins over a software clear in the same cycle.
module ppe_sticky
(
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic resetn,
   // Event and clear.
   input  wire logic setEvent,
   input  wire logic clearReq,
   // Stored flag.
   output logic      flag
);

   //---------------------------------------------------------------------------
   // Flag storage
   //---------------------------------------------------------------------------
   // sticky until clear
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         flag <= 1'b0;
      else if (setEvent)
         flag <= 1'b1;
      else if (clearReq)
         flag <= 1'b0;
   end

   a_set_wins: assert property (@(posedge core_clk) disable iff (!resetn)
      setEvent |=> flag) else $error("sticky flag lost an event");

endmodule : ppe_sticky

// ===== ppe_perr_drive.sv
`timescale 1ns/1ns
// Registered active-low parity error pin driver for one bus.
module ppe_perr_drive
(
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic resetn,
   // Request to assert and permission to drive.
   input  wire logic assertReq,
   input  wire logic driveOk,
   // Pin signals.
   output logic      perrOut_n,
   output logic      perrOe
);

   //---------------------------------------------------------------------------
   // Pin registers
   //---------------------------------------------------------------------------
   // The pin stays high whenever driven without an error.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         perrOut_n <= 1'b1;
         perrOe    <= 1'b0;
      end
      else
      begin
         perrOe    <= driveOk;
         perrOut_n <= !(assertReq && driveOk);
      end
   end

   a_low_needs_oe: assert property (@(posedge core_clk) disable iff (!resetn)
      !perrOut_n |-> perrOe) else $error("error pin low while not driven");

endmodule : ppe_perr_drive

// ===== ppe_parity_report.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Data parity error reporting for a two-port bridge.
module ppe_parity_report
(
   // Clock and reset.
   input  wire logic                      core_clk,
   input  wire logic                      resetn,
   // Register port.
   input  wire logic [ppe_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [31:0]               regWdata,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   output logic      [31:0]               regRdata,
   // Transaction context, synchronous to core_clk.
   input  wire ppe_pkg::ppe_kind_type     txKind,
   input  wire logic                      txUpstream,
   input  wire logic                      priMaster,
   input  wire logic                      secMaster,
   input  wire logic                      priWrTarget,
   input  wire logic                      secWrTarget,
   input  wire logic                      priReadInit,
   input  wire logic                      secReadInit,
   input  wire logic                      dlyCompletion,
   // Own parity mismatch on each bus.
   input  wire logic                      priMismatch,
   input  wire logic                      secMismatch,
   // Parity error pins.
   input  wire logic                      primary_parity_err_n_in,
   output logic                           primary_parity_err_n_out,
   output logic                           primary_parity_err_n_oe,
   input  wire logic                      secondary_parity_err_n_in,
   output logic                           secondary_parity_err_n_out,
   output logic                           secondary_parity_err_n_oe,
   // Interrupt.
   output logic                           irq
);

   //---------------------------------------------------------------------------
   // Register state
   //---------------------------------------------------------------------------
   logic [1:0] ctrl;      // Response enables.
   logic [1:0] irqEn;     // Interrupt enables.
   logic [1:0] status;    // Sticky detected bits.
   logic       priEn;     // Primary response enable.
   logic       secEn;     // Secondary response enable.
   logic       isXfer;    // A data-carrying transaction is active.
   logic       priErr;    // Any error seen on the primary bus.
   logic       secErr;    // Any error seen on the secondary bus.
   logic       setPri;    // Primary detected bit event.
   logic       setSec;    // Secondary detected bit event.
   logic       fwdUp;     // Secondary error forwarded up.
   logic       fwdDown;   // Primary error forwarded down.
   logic       priAssert; // Primary pin assertion request.
   logic       secAssert; // Secondary pin assertion request.
   logic       clrWr;     // Write to the clear register.

   assign priEn  = ctrl[ppe_pkg::BIT_PRI_EN];
   assign secEn  = ctrl[ppe_pkg::BIT_SEC_EN];
   assign isXfer = (txKind != ppe_pkg::KIND_NONE);
   assign clrWr  = regWrite && (regAddr == ppe_pkg::OFF_CLEAR);

   //---------------------------------------------------------------------------
   // Detection
   //---------------------------------------------------------------------------
   // primary and secondary trigger sources
   assign priErr = !primary_parity_err_n_in || priMismatch;
   assign secErr = !secondary_parity_err_n_in || secMismatch;

   // primary master bit; upstream only, with primary enable.
   assign setPri = isXfer && priMaster && txUpstream && priErr && priEn;
   // secondary master bit; downstream only, with secondary enable.
   assign setSec = isXfer && secMaster && !txUpstream && secErr && secEn;

   //---------------------------------------------------------------------------
   // Pin assertion decisions
   //---------------------------------------------------------------------------
   // forward secondary error on downstream delayed write completion.
   assign fwdUp = (txKind == ppe_pkg::KIND_DELAYED) && !txUpstream && dlyCompletion
                  && !secondary_parity_err_n_in && priEn && secEn;
   // forward primary error on upstream delayed write completion.
   assign fwdDown = (txKind == ppe_pkg::KIND_DELAYED) && txUpstream && dlyCompletion
                    && !primary_parity_err_n_in && priEn && secEn;

   // primary cases: upstream read, downstream writes.
   assign priAssert = fwdUp || (priEn && priMismatch &&
                      (((txKind == ppe_pkg::KIND_READ) && txUpstream) ||
                       (((txKind == ppe_pkg::KIND_POSTED) ||
                         (txKind == ppe_pkg::KIND_DELAYED)) && !txUpstream)));
   // secondary cases: downstream read, upstream writes.
   assign secAssert = fwdDown || (secEn && secMismatch &&
                      (((txKind == ppe_pkg::KIND_READ) && !txUpstream) ||
                       (((txKind == ppe_pkg::KIND_POSTED) ||
                         (txKind == ppe_pkg::KIND_DELAYED)) && txUpstream)));

   //---------------------------------------------------------------------------
   // Pin drivers
   //---------------------------------------------------------------------------
   // drive only as write target or read initiator, enabled.
   ppe_perr_drive u_priDrive
   (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .assertReq (priAssert),
      .driveOk   ((priWrTarget || priReadInit) && priEn),
      .perrOut_n (primary_parity_err_n_out),
      .perrOe    (primary_parity_err_n_oe)
   );

   ppe_perr_drive u_secDrive
   (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .assertReq (secAssert),
      .driveOk   ((secWrTarget || secReadInit) && secEn),
      .perrOut_n (secondary_parity_err_n_out),
      .perrOe    (secondary_parity_err_n_oe)
   );

   //---------------------------------------------------------------------------
   // Status bits
   //---------------------------------------------------------------------------
   // write one clears each bit, events win.
   ppe_sticky u_priSticky
   (
      .core_clk (core_clk),
      .resetn   (resetn),
      .setEvent (setPri),
      .clearReq (clrWr && regWdata[ppe_pkg::BIT_PRI]),
      .flag     (status[ppe_pkg::BIT_PRI])
   );

   ppe_sticky u_secSticky
   (
      .core_clk (core_clk),
      .resetn   (resetn),
      .setEvent (setSec),
      .clearReq (clrWr && regWdata[ppe_pkg::BIT_SEC]),
      .flag     (status[ppe_pkg::BIT_SEC])
   );

   //---------------------------------------------------------------------------
   // Register writes
   //---------------------------------------------------------------------------
   // Control and interrupt enable registers.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl  <= ppe_pkg::RST_CTRL;
         irqEn <= ppe_pkg::RST_IRQEN;
      end
      else if (regWrite)
      begin
         if (regAddr == ppe_pkg::OFF_CTRL)
            ctrl <= regWdata[1:0];
         if (regAddr == ppe_pkg::OFF_IRQEN)
            irqEn <= regWdata[1:0];
      end
   end

   //---------------------------------------------------------------------------
   // Register reads
   //---------------------------------------------------------------------------
   // Read data appear one cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         regRdata <= 32'h0000_0000;
      else if (regRead)
      begin
         case (regAddr)
            ppe_pkg::OFF_STATUS: regRdata <= {30'h0, status};
            ppe_pkg::OFF_IRQEN:  regRdata <= {30'h0, irqEn};
            ppe_pkg::OFF_CTRL:   regRdata <= {30'h0, ctrl};
            default:             regRdata <= 32'h0000_0000;
         endcase
      end
      else
         regRdata <= 32'h0000_0000;
   end

   //---------------------------------------------------------------------------
   // Interrupt
   //---------------------------------------------------------------------------
   // Level interrupt; registered, so it lags status by one cycle.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= |(status & irqEn);
   end

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   a_pri_needs_en: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(status[ppe_pkg::BIT_PRI]) |-> $past(priEn)) else $error("pri bit without enable");
   a_pri_upstream: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(status[ppe_pkg::BIT_PRI]) |-> $past(txUpstream) && $past(priMaster))
      else $error("pri bit on wrong direction");
   a_sec_downstream: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(status[ppe_pkg::BIT_SEC]) |-> !$past(txUpstream) && $past(secEn))
      else $error("sec bit on wrong direction");
   a_pri_pin_en: assert property (@(posedge core_clk) disable iff (!resetn)
      !primary_parity_err_n_out |-> $past(priEn)) else $error("pri pin without enable");
   a_sec_pin_en: assert property (@(posedge core_clk) disable iff (!resetn)
      !secondary_parity_err_n_out |-> $past(secEn)) else $error("sec pin without enable");
   a_pri_drive_win: assert property (@(posedge core_clk) disable iff (!resetn)
      primary_parity_err_n_oe |-> $past(priWrTarget) || $past(priReadInit))
      else $error("pri driven outside window");
   a_sec_drive_win: assert property (@(posedge core_clk) disable iff (!resetn)
      secondary_parity_err_n_oe |-> $past(secWrTarget) || $past(secReadInit))
      else $error("sec driven outside window");
   a_fwd_up: assert property (@(posedge core_clk) disable iff (!resetn)
      fwdUp && priWrTarget |=> !primary_parity_err_n_out) else $error("forward up missed");
   a_fwd_down: assert property (@(posedge core_clk) disable iff (!resetn)
      fwdDown && secWrTarget |=> !secondary_parity_err_n_out) else $error("forward down missed");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!resetn)
      irq |-> |($past(status) & $past(irqEn))) else $error("irq without cause");

   c_pri_set:  cover property (@(posedge core_clk) $rose(status[ppe_pkg::BIT_PRI]));
   c_sec_set:  cover property (@(posedge core_clk) $rose(status[ppe_pkg::BIT_SEC]));
   c_fwd_up:   cover property (@(posedge core_clk) fwdUp);
   c_fwd_down: cover property (@(posedge core_clk) fwdDown);
   c_irq_rise: cover property (@(posedge core_clk) $rose(irq));

endmodule : ppe_parity_report

// ===== ppe_pci_agent.sv
`timescale 1ns/1ns
//------------------------------------------------------------------------------
// Bus agent model for one parity error line
//------------------------------------------------------------------------------
// Models the other agents on one bus and the line's pull-up resistor.
module ppe_pci_agent
(
   // Agent request to report a parity error.
   input  wire logic errReq,
   // Bridge side of the same line.
   input  wire logic drvOut_n,
   input  wire logic drvOe,
   // Resolved line level.
   output logic      pin_n
);
   // The line is wired-AND with a pull-up, so a released line reads high.
   assign pin_n = ~(errReq | (drvOe & ~drvOut_n));
endmodule : ppe_pci_agent

// ===== tb_pci_bridge_parity_error_report.sv
`timescale 1ns/1ns
//------------------------------------------------------------------------------
// Testbench
//------------------------------------------------------------------------------
module tb_pci_bridge_parity_error_report;
   logic core_clk, resetn, regWrite, regRead, txUpstream, dlyCompletion;
   logic [3:0]  regAddr;
   logic [31:0] regWdata, regRdata;
   ppe_pkg::ppe_kind_type txKind;
   logic priMaster, secMaster, priWrTarget, secWrTarget, priReadInit, secReadInit;
   logic priMismatch, secMismatch, priPin_n, secPin_n, irq, agentPri, agentSec;
   logic priOut_n, priOe, secOut_n, secOe;
   int   mismatches = 0;
   int   nTests     = 0;
   // Every design input starts at a defined idle value.
   initial
   begin
      {regWrite, regRead, txUpstream, dlyCompletion, priMaster, secMaster} = '0;
      {priWrTarget, secWrTarget, priReadInit, secReadInit} = '0;
      {priMismatch, secMismatch, agentPri, agentSec} = '0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      txKind = ppe_pkg::KIND_NONE;
      resetn = 1'b0;
   end
   // The clock runs at 100 MHz.
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   ppe_parity_report i_dut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .txKind(txKind), .txUpstream(txUpstream), .priMaster(priMaster), .secMaster(secMaster),
      .priWrTarget(priWrTarget), .secWrTarget(secWrTarget), .priReadInit(priReadInit),
      .secReadInit(secReadInit), .dlyCompletion(dlyCompletion), .priMismatch(priMismatch),
      .secMismatch(secMismatch), .primary_parity_err_n_in(priPin_n),
      .primary_parity_err_n_out(priOut_n), .primary_parity_err_n_oe(priOe),
      .secondary_parity_err_n_in(secPin_n), .secondary_parity_err_n_out(secOut_n),
      .secondary_parity_err_n_oe(secOe), .irq(irq));
   // Both buses carry other agents that can pull the line low.
   ppe_pci_agent i_priAgent (.errReq(agentPri), .drvOut_n(priOut_n), .drvOe(priOe),
      .pin_n(priPin_n));
   ppe_pci_agent i_secAgent (.errReq(agentSec), .drvOut_n(secOut_n), .drvOe(secOe),
      .pin_n(secPin_n));
   //---------------------------------------------------------------------------
   // Shared tasks
   //---------------------------------------------------------------------------
   task automatic conclude;
      if (mismatches == 0 && nTests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One write cycle; the strobe drops at the edge that took it.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   // One read cycle; the data stand only in the following cycle.
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      check(regRdata, exp);
   endtask : rd
   // Presents one transaction context for a single sampling edge.
   task automatic ctx(input int k, input int u, input logic pm, input logic sm,
                      input logic pe, input logic se);
      @(posedge core_clk);
      txKind <= ppe_pkg::ppe_kind_type'(k);
      txUpstream <= u[0];
      priMaster <= pm;
      secMaster <= sm;
      priMismatch <= pe;
      secMismatch <= se;
      @(posedge core_clk);
      {priMaster, secMaster, priMismatch, secMismatch} <= 4'h0;
      #1;
   endtask : ctx
   //---------------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------------
   task automatic test_reset;
      check({29'h0, priOut_n, priOe, irq}, 32'h4);
      rd(ppe_pkg::OFF_CTRL, 32'(ppe_pkg::RST_CTRL));
      rd(ppe_pkg::OFF_IRQEN, 32'(ppe_pkg::RST_IRQEN));
      rd(ppe_pkg::OFF_STATUS, 32'h0);
      rd(4'hF, 32'h0);
   endtask : test_reset
   task automatic test_status;
      logic [31:0] e;
      for (int c = 0; c < 4; c++)
      begin
         wr(ppe_pkg::OFF_CTRL, 32'(c));
         for (int k = 0; k < 4; k++)
            for (int u = 0; u < 2; u++)
               for (int b = 0; b < 2; b++)
               begin
                  ctx(k, u, 1'b1, 1'b1, b == 0, b == 1);
                  e = '0;
                  e[0] = c[0] && u == 1 && b == 0 && k != 3;
                  e[1] = c[1] && u == 0 && b == 1 && k != 3;
                  rd(ppe_pkg::OFF_STATUS, e);
                  wr(ppe_pkg::OFF_CLEAR, 32'h3);
               end
      end
   endtask : test_status
   // sampled line trigger and master gating.
   task automatic test_trigger;
      wr(ppe_pkg::OFF_CTRL, 32'h3);
      agentPri <= 1'b1;
      ctx(0, 1, 1'b1, 1'b0, 1'b0, 1'b0);
      agentPri <= 1'b0;
      agentSec <= 1'b1;
      ctx(0, 0, 1'b0, 1'b1, 1'b0, 1'b0);
      agentSec <= 1'b0;
      rd(ppe_pkg::OFF_STATUS, 32'h3);
      wr(ppe_pkg::OFF_CLEAR, 32'h3);
      ctx(0, 1, 1'b0, 1'b0, 1'b1, 1'b0);
      ctx(0, 0, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(ppe_pkg::OFF_STATUS, 32'h0);
   endtask : test_trigger
   task automatic test_pins;
      logic hp, hs;
      for (int c = 0; c < 4; c++)
      begin
         wr(ppe_pkg::OFF_CTRL, 32'(c));
         for (int w = 0; w < 3; w++)
            for (int k = 0; k < 4; k++)
               for (int u = 0; u < 2; u++)
                  for (int b = 0; b < 2; b++)
                  begin
                     {priWrTarget, secWrTarget} <= {2{w == 1}};
                     {priReadInit, secReadInit} <= {2{w == 2}};
                     ctx(k, u, 1'b0, 1'b0, b == 0, b == 1);
                     hp = b == 0 && ((k == 0 && u == 1) || ((k == 1 || k == 2) && u == 0));
                     hs = b == 1 && ((k == 0 && u == 0) || ((k == 1 || k == 2) && u == 1));
                     check(32'(priOe), 32'(w != 0 && c[0]));
                     check(32'(priOut_n), 32'(!(w != 0 && c[0] && hp)));
                     check(32'(secOe), 32'(w != 0 && c[1]));
                     check(32'(secOut_n), 32'(!(w != 0 && c[1] && hs)));
                  end
      end
      {priWrTarget, secWrTarget, priReadInit, secReadInit} <= 4'h0;
   endtask : test_pins
   task automatic test_forward;
      for (int c = 1; c < 4; c++)
      begin
         wr(ppe_pkg::OFF_CTRL, 32'(c));
         dlyCompletion <= 1'b1;
         priWrTarget <= 1'b1;
         agentSec <= 1'b1;
         ctx(2, 0, 1'b0, 1'b0, 1'b0, 1'b0);
         check(32'(priOut_n), 32'(c != 3));
         {priWrTarget, agentSec} <= 2'h0;
         {secWrTarget, agentPri} <= 2'h3;
         ctx(2, 1, 1'b0, 1'b0, 1'b0, 1'b0);
         check(32'(secOut_n), 32'(c != 3));
         {secWrTarget, agentPri, dlyCompletion} <= 3'h0;
      end
   endtask : test_forward
   task automatic test_sticky;
      wr(ppe_pkg::OFF_CTRL, 32'h3);
      wr(ppe_pkg::OFF_IRQEN, 32'h1);
      ctx(0, 1, 1'b1, 1'b0, 1'b1, 1'b0);
      @(posedge core_clk);
      #1;
      check(32'(irq), 32'h1);
      wr(ppe_pkg::OFF_STATUS, 32'h0);
      wr(ppe_pkg::OFF_CLEAR, 32'h2);
      rd(ppe_pkg::OFF_STATUS, 32'h1);
      wr(ppe_pkg::OFF_IRQEN, 32'h0);
      @(posedge core_clk);
      #1;
      check(32'(irq), 32'h0);
      wr(ppe_pkg::OFF_CLEAR, 32'h1);
      rd(ppe_pkg::OFF_STATUS, 32'h0);
   endtask : test_sticky
   //---------------------------------------------------------------------------
   // Main sequence and watchdog
   //---------------------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      test_reset();
      test_status();
      test_trigger();
      test_pins();
      test_forward();
      test_sticky();
      conclude();
   end
   // The tests need about 850 cycles; this span of 30,000 cycles leaves a wide margin.
   initial
   begin
      #300000;
      mismatches++;
      conclude();
   end
endmodule : tb_pci_bridge_parity_error_report
